// ==== hw/fbs_pkg.sv ====
// Shared constants, types and states of the fieldbus slave I/O block
package fbs_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ     = 20;
  localparam int SETUP_NS    = 500;
  localparam int STB_NS      = 1000;
  localparam int HALF_BIT_NS = 3000;
  localparam int WDOG_MS     = 327;
  localparam int SETUP_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STB_CYC     = (STB_NS * CLK_MHZ + 999) / 1000;
  localparam int HALF_CYC    = (HALF_BIT_NS * CLK_MHZ) / 1000;
  localparam int WDOG_CYC    = WDOG_MS * CLK_MHZ * 1000;
  localparam int INIT_CYC    = 3;
  // ==========================================================
  // Register map (byte offsets)
  localparam logic [3:0]  OFS_CTRL = 4'h0;
  localparam logic [3:0]  OFS_CODE = 4'h4;
  localparam logic [3:0]  OFS_STAT = 4'h8;
  localparam logic [31:0] CTRL_RST = 32'h0000300F;
  localparam logic [31:0] CODE_RST = 32'h00000000;
  // ==========================================================
  // Port behaviour
  localparam logic [3:0] PAR_BIDIR_CODE = 4'h7;
  localparam logic [3:0] DOUT_RST       = 4'hF;
  localparam logic [1:0] SAME_ADDR_MAX  = 2'h3;
  localparam logic [1:0] LVL_HIGH       = 2'h3;
  localparam logic [3:0] FAULT_WORD     = 4'h0;
  localparam logic [6:0] FRAME_IDLE     = 7'h7F;
  // ==========================================================
  // Types
  typedef struct packed {
    logic [3:0] filt_len;
    logic       rsvd;
    logic       safety;
    logic       wdog_en;
    logic       four_out;
    logic       ext_addr;
    logic       sync_en;
    logic       filt_en;
    logic       invert;
    logic [3:0] io_code;
  } fbs_cfg_s;

  typedef struct packed {
    logic       data_exchange_call;
    logic [4:0] addr;
    logic [4:0] info;
  } fbs_tlg_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DRIVE  = 3'b001,
    ST_STROBE = 3'b010,
    ST_SAMPLE = 3'b011,
    ST_SEND   = 3'b100
  } fbs_state_e;
endpackage

// ==== hw/fbs_slave_io.sv ====
// Role selection and slave port processing of the fieldbus interface
`timescale 1ns/10ps
module fbs_slave_io
  import fbs_pkg::*;
#(
  parameter int WDOG_LIMIT = WDOG_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        NV_MASTER_MODE,
  input  wire logic        RX_STB,
  input  wire logic        RX_OK,
  input  wire logic        RX_MINE,
  input  wire fbs_tlg_s    RX_TLG,
  input  wire logic [3:0]  DATA_PORT_IN,
  output logic      [3:0]  DATA_PORT_OUT,
  output logic      [3:0]  DATA_PORT_OE,
  input  wire logic [3:0]  PARAM_PORT_IN,
  output logic      [3:0]  PARAM_PORT_OUT,
  output logic      [3:0]  PARAM_PORT_OE,
  output logic             DATA_STROBE_N,
  output logic             PARAM_STROBE_N,
  input  wire logic [7:0]  SAFE_LVL_IN,
  input  wire logic        MASTER_TXD,
  input  wire logic        MASTER_RX_PULSE,
  output logic             MASTER_RXD,
  output logic             MASTER_RX_STB,
  output logic             TX_DATA,
  output logic             TX_ACTIVE,
  output logic             ROLE_MASTER
);
  // ==========================================================
  // Helpers
  function automatic logic [3:0] out_update(input logic [3:0] cur,
                                            input logic [4:0] info,
                                            input fbs_cfg_s   c);
    logic [3:0] r;
    r = cur;
    if (!c.ext_addr)
      r = info[3:0];
    else if (!c.four_out)
      r[2:0] = info[2:0];
    else if (info[2])
      r[3:2] = info[1:0];
    else
      r[1:0] = info[1:0];
    return r;
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [3:0] din_m, din_s, pin_m, pin_s;
  logic [7:0] lvl_m, lvl_s;
  logic       nv_m, nv_s, txd_m, txd_s, rxp_m, rxp_s;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      {din_m, din_s, pin_m, pin_s} <= 16'h0000;
      {lvl_m, lvl_s} <= 16'h0000;
      {nv_m, nv_s, txd_m, txd_s, rxp_m, rxp_s} <= 6'h00;
    end else begin
      din_m <= DATA_PORT_IN;
      din_s <= din_m;
      pin_m <= PARAM_PORT_IN;
      pin_s <= pin_m;
      lvl_m <= SAFE_LVL_IN;
      lvl_s <= lvl_m;
      nv_m  <= NV_MASTER_MODE;
      nv_s  <= nv_m;
      txd_m <= MASTER_TXD;
      txd_s <= txd_m;
      rxp_m <= MASTER_RX_PULSE;
      rxp_s <= rxp_m;
    end
  end

  // ==========================================================
  // Role capture
  // Waits for the strap to pass the synchroniser before taking it
  logic [1:0] init_cnt;
  logic       init_done, role;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      init_cnt  <= 2'h0;
      init_done <= 1'b0;
      role      <= 1'b0;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 2'h1;
      if (init_cnt == 2'(INIT_CYC - 1)) begin
        init_done <= 1'b1;
        role      <= nv_s;
      end
    end
  end
  assign ROLE_MASTER = role;
  wire slave_on = init_done && !role;

  // ==========================================================
  // Register bus
  logic [31:0] ctrl, code;
  fbs_cfg_s    cfg;
  assign cfg = fbs_cfg_s'(ctrl[15:0]);
  wire wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  logic [31:0] stat;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl     <= CTRL_RST;
      code     <= CODE_RST;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req && WB_WE_I) begin
        for (int b = 0; b < 4; b++) begin
          if (WB_SEL_I[b] && WB_ADR_I == OFS_CTRL)
            ctrl[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
          if (WB_SEL_I[b] && WB_ADR_I == OFS_CODE)
            code[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
        end
      end
      if (wb_req && !WB_WE_I)
        unique case (WB_ADR_I)
          OFS_CTRL: WB_DAT_O <= ctrl;
          OFS_CODE: WB_DAT_O <= code;
          OFS_STAT: WB_DAT_O <= stat;
          default:  WB_DAT_O <= 32'h00000000;
        endcase
    end
  end

  // ==========================================================
  // Input filter
  // One counter for the whole port: a bounce on any pin restarts it
  logic [3:0] flt_last, flt_val, flt_cnt, din_eff;
  logic       flt_on;
  assign flt_on  = (cfg.filt_en || pin_s[2]) && !cfg.safety;
  assign din_eff = (flt_on ? flt_val : din_s)
                   ^ {4{cfg.invert && !cfg.safety}};
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      flt_last <= 4'h0;
      flt_val  <= 4'h0;
      flt_cnt  <= 4'h0;
    end else if (din_s != flt_last) begin
      flt_last <= din_s;
      flt_cnt  <= 4'h0;
    end else if (flt_cnt < cfg.filt_len) begin
      flt_cnt <= flt_cnt + 4'h1;
    end else begin
      flt_val <= din_s;
    end
  end

  // ==========================================================
  // Call decode
  wire good  = RX_STB && RX_OK && slave_on;
  wire sync_on = cfg.sync_en && !cfg.safety;
  wire my_dx = good && RX_TLG.data_exchange_call && RX_MINE;
  wire my_wp = good && !RX_TLG.data_exchange_call && RX_MINE;

  // ==========================================================
  // Synchronous I/O tracking
  logic [4:0] last_addr;
  logic [1:0] same_cnt;
  logic       sync_started, sync_pt;
  always_comb begin
    sync_pt = 1'b0;
    if (good && RX_TLG.data_exchange_call && sync_on) begin
      if (!sync_started)
        sync_pt = 1'b1;
      else if (RX_TLG.addr < last_addr)
        sync_pt = 1'b1;
      else if (RX_TLG.addr == last_addr && same_cnt == SAME_ADDR_MAX)
        sync_pt = 1'b1;
    end
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      last_addr    <= 5'h00;
      same_cnt     <= 2'h0;
      sync_started <= 1'b0;
    end else if (!sync_on) begin
      sync_started <= 1'b0;
      same_cnt     <= 2'h0;
    end else if (good && RX_TLG.data_exchange_call) begin
      sync_started <= 1'b1;
      last_addr    <= RX_TLG.addr;
      // Counts telegrams of the current run, the first one included
      if (RX_TLG.addr != last_addr || same_cnt == SAME_ADDR_MAX)
        same_cnt <= 2'h1;
      else
        same_cnt <= same_cnt + 2'h1;
    end
  end

  // ==========================================================
  // Nibble alternation watchdog
  logic [22:0] wd_cnt;
  logic        wd_exp, last_i2;
  wire wd_on = cfg.wdog_en && cfg.ext_addr && cfg.four_out && slave_on;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wd_cnt  <= 23'h000000;
      wd_exp  <= 1'b0;
      last_i2 <= 1'b0;
    end else if (!wd_on) begin
      wd_cnt <= 23'h000000;
      wd_exp <= 1'b0;
    end else if (my_dx && RX_TLG.info[2] != last_i2) begin
      last_i2 <= RX_TLG.info[2];
      wd_cnt  <= 23'h000000;
      wd_exp  <= 1'b0;
    end else if (wd_cnt == 23'(WDOG_LIMIT - 1)) begin
      wd_exp <= 1'b1;
    end else begin
      wd_cnt <= wd_cnt + 23'h000001;
      if (my_dx)
        last_i2 <= RX_TLG.info[2];
    end
  end

  // ==========================================================
  // Port sequencer
  // Outputs settle SETUP_CYC - 2 cycles before the strobe falls; inputs are
  // caught as the strobe rises, so the strobe edge is a safe trigger
  fbs_state_e  st;
  logic        kind_par;
  logic [7:0]  tmr;
  logic [3:0]  dout, dpend, held, pout, resp;
  logic [2:0]  code_idx;
  logic        dstb_n, pstb_n;
  logic [4:0]  info;
  wire par_bidir = cfg.io_code == PAR_BIDIR_CODE;
  wire safe_ok = lvl_s[1:0] == LVL_HIGH && lvl_s[3:2] == LVL_HIGH
              && lvl_s[5:4] == LVL_HIGH && lvl_s[7:6] == LVL_HIGH;
  logic [6:0]  frame;
  logic [2:0]  bit_cnt;
  logic [5:0]  half_cnt;
  logic        half2;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st       <= ST_IDLE;
      kind_par <= 1'b0;
      tmr      <= 8'h00;
      info     <= 5'h00;
      dstb_n   <= 1'b1;
      pstb_n   <= 1'b1;
      resp     <= 4'h0;
      code_idx <= 3'h0;
    end else begin
      unique case (st)
        ST_IDLE: begin
          if (my_dx || my_wp) begin
            kind_par <= my_wp;
            info     <= RX_TLG.info;
            tmr      <= 8'h00;
            st       <= ST_DRIVE;
            if (my_dx && cfg.safety)
              code_idx <= code_idx + 3'h1;
          end
        end
        ST_DRIVE: begin
          tmr <= tmr + 8'h01;
          if (tmr == 8'(SETUP_CYC - 1)) begin
            tmr <= 8'h00;
            st  <= ST_STROBE;
            if (kind_par)
              pstb_n <= 1'b0;
            else
              dstb_n <= 1'b0;
          end
        end
        ST_STROBE: begin
          tmr <= tmr + 8'h01;
          if (tmr == 8'(STB_CYC - 1)) begin
            st     <= ST_SAMPLE;
            dstb_n <= 1'b1;
            pstb_n <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          st <= ST_SEND;
          if (kind_par)
            resp <= par_bidir ? pin_s : pout;
          else if (cfg.safety)
            resp <= safe_ok ? code[{code_idx - 3'h1, 2'b00} +: 4]
                            : FAULT_WORD;
          else if (sync_on)
            resp <= held;
          else
            resp <= din_eff;
        end
        ST_SEND: begin
          // Stay busy until the last half bit, so no call cuts the frame
          if (TX_ACTIVE && half2 && bit_cnt == 3'h1
              && half_cnt == 6'(HALF_CYC - 1))
            st <= ST_IDLE;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end
  assign DATA_STROBE_N  = dstb_n;
  assign PARAM_STROBE_N = pstb_n;

  // ==========================================================
  // Output ports
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      dout  <= DOUT_RST;
      dpend <= DOUT_RST;
      held  <= 4'h0;
      pout  <= 4'hF;
    end else begin
      if (wd_exp)
        dout <= DOUT_RST;
      else if (sync_pt)
        dout <= dpend;
      else if (st == ST_DRIVE && tmr == 8'h00 && !kind_par && !sync_on)
        dout <= out_update(dout, info, cfg);
      if (sync_pt)
        held <= din_eff;
      if (st == ST_DRIVE && tmr == 8'h00 && !kind_par)
        dpend <= out_update(dpend, info, cfg);
      if (st == ST_DRIVE && tmr == 8'h00 && kind_par)
        pout <= info[3:0];
    end
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      DATA_PORT_OUT  <= 4'h0;
      DATA_PORT_OE   <= 4'h0;
      PARAM_PORT_OUT <= 4'h0;
      PARAM_PORT_OE  <= 4'h0;
    end else begin
      DATA_PORT_OUT <= 4'h0;
      PARAM_PORT_OUT <= 4'h0;
      // Open drain: a pin is driven only while its level is low
      DATA_PORT_OE <= slave_on ? cfg.io_code & ~dout : 4'h0;
      // Bidirectional pins are released from one cycle after the strobe falls until two cycles after it rises, so the
      // level has passed the synchroniser when it is sampled
      PARAM_PORT_OE <= (slave_on && !(par_bidir
                        && (st == ST_STROBE || st == ST_SAMPLE)))
                       ? ~pout : 4'h0;
    end
  end

  // ==========================================================
  // Transmit path
  // Half-bit pacing; first half carries the inverse of the bit
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      frame     <= FRAME_IDLE;
      bit_cnt   <= 3'h0;
      half_cnt  <= 6'h00;
      half2     <= 1'b0;
      TX_ACTIVE <= 1'b0;
      TX_DATA   <= 1'b1;
    end else if (role && init_done) begin
      TX_DATA   <= txd_s;
      TX_ACTIVE <= 1'b0;
    end else if (st == ST_SAMPLE) begin
      frame     <= FRAME_IDLE; // loaded next cycle from resp
      TX_ACTIVE <= 1'b0;
    end else if (st == ST_SEND && !TX_ACTIVE && bit_cnt == 3'h0) begin
      frame     <= {1'b0, resp, ^resp, 1'b1};
      bit_cnt   <= 3'h7;
      half_cnt  <= 6'h00;
      half2     <= 1'b0;
      TX_ACTIVE <= 1'b1;
      TX_DATA   <= 1'b1;
    end else if (TX_ACTIVE) begin
      TX_DATA <= half2 ? frame[6] : ~frame[6];
      if (half_cnt == 6'(HALF_CYC - 1)) begin
        half_cnt <= 6'h00;
        half2    <= !half2;
        if (half2) begin
          frame   <= {frame[5:0], 1'b1};
          bit_cnt <= bit_cnt - 3'h1;
          if (bit_cnt == 3'h1) begin
            TX_ACTIVE <= 1'b0;
            bit_cnt   <= 3'h0;
          end
        end
      end else begin
        half_cnt <= half_cnt + 6'h01;
      end
    end else begin
      TX_DATA <= 1'b1;
    end
  end

  // ==========================================================
  // Master role receive side
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      MASTER_RXD    <= 1'b0;
      MASTER_RX_STB <= 1'b0;
    end else begin
      MASTER_RXD    <= role && init_done && rxp_s;
      MASTER_RX_STB <= role && init_done && RX_STB && RX_OK;
    end
  end

  assign stat = {16'h0000, 1'b0, code_idx, wd_exp, sync_started,
                 role, init_done, dout, din_eff};

  // ==========================================================
  // Checks
  // Strobe width counter, helper for the width check only
  logic [7:0] stb_lo_cnt;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN)
      stb_lo_cnt <= 8'h00;
    else if (!dstb_n)
      stb_lo_cnt <= stb_lo_cnt + 8'h01;
    else
      stb_lo_cnt <= 8'h00;
  end
  role_stable_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    init_done |=> $stable(role) && init_done)
    else $error("role changed while running");
  dstb_order_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(dstb_n) |=> st == ST_SEND)
    else $error("data inputs not sampled as strobe rose");
  dstb_len_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(dstb_n) |-> stb_lo_cnt == 8'(STB_CYC))
    else $error("data strobe width wrong");
  pstb_kind_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    !pstb_n |-> kind_par && dstb_n)
    else $error("parameter strobe on a data call");
  resp_plain_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    st == ST_SAMPLE && !kind_par && !cfg.safety && !sync_on
    |=> resp == $past(din_eff))
    else $error("send register does not hold sampled inputs");
  safe_noinv_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    cfg.safety |-> din_eff == din_s)
    else $error("input features active in safety mode");
  master_tx_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    role && init_done |=> TX_DATA == $past(txd_s))
    else $error("transmit pin not forwarded");
  rx_strobe_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    MASTER_RX_STB |-> $past(RX_OK) && $past(RX_STB))
    else $error("receive strobe on a bad telegram");
  code_step_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    st == ST_IDLE && my_dx && cfg.safety
    |=> code_idx == $past(code_idx) + 3'h1)
    else $error("code table did not step");
  wdog_exp_a: assert property (@(posedge MCLK) disable iff (!RSTN)
    wd_on && wd_cnt == 23'(WDOG_LIMIT - 1) && !my_dx |=> wd_exp)
    else $error("watchdog did not expire");
  data_cov_c: cover property (@(posedge MCLK) $rose(dstb_n));
  par_cov_c: cover property (@(posedge MCLK) $rose(pstb_n));
  sync_cov_c: cover property (@(posedge MCLK) sync_pt && sync_started);
  wd_cov_c: cover property (@(posedge MCLK) $rose(wd_exp));
endmodule

// ==== testbench/fbs_master_model.sv ====
// Bus master model: sends telegram strobes, decodes slave responses
`timescale 1ns/10ps
module fbs_master_model
  import fbs_pkg::*;
(
  input  wire logic MCLK,
  input  wire logic TX_DATA,
  input  wire logic TX_ACTIVE,
  output logic      RX_STB,
  output logic      RX_OK,
  output logic      RX_MINE,
  output fbs_tlg_s  RX_TLG
);
  initial begin
    RX_STB = 1'b0;
    RX_OK = 1'b0;
    RX_MINE = 1'b0;
    RX_TLG = '0;
  end
  // ==========================================================
  // Telegram strobe; qualifiers flip once idle so none goes stale
  task automatic send(input logic dx, input logic [4:0] a,
                      input logic [4:0] inf, input logic me,
                      input logic ok);
    RX_STB <= 1'b1;
    RX_OK <= ok;
    RX_MINE <= me;
    RX_TLG <= {dx, a, inf};
    @(posedge MCLK);
    RX_STB <= 1'b0;
    RX_OK <= ~ok;
    RX_MINE <= ~me;
    RX_TLG <= ~{dx, a, inf};
  endtask
  // ==========================================================
  // Decode: middle of each second half carries the bit value
  task automatic get_resp(output logic [3:0] d, output logic good);
    logic [6:0] f;
    int n;
    n = 0;
    f = 7'h00;
    while (TX_ACTIVE !== 1'b1 && n < 200) begin
      @(negedge MCLK);
      n++;
    end
    for (int b = 6; b >= 0; b--) begin
      repeat (b == 6 ? 3 * HALF_CYC / 2 : 2 * HALF_CYC) @(negedge MCLK);
      f[b] = TX_DATA;
    end
    d = f[5:2];
    good = (n < 200) && !f[6] && f[0] && (f[1] == ^f[5:2]);
    n = 0;
    while (TX_ACTIVE === 1'b1 && n < 200) begin
      @(negedge MCLK);
      n++;
    end
    good = good && (n < 200) && (TX_DATA === 1'b1);
  endtask
endmodule

// ==== testbench/fbs_slave_io_tb.sv ====
// Self-checking testbench of the fieldbus slave I/O block
`timescale 1ns/10ps
module fbs_slave_io_tb
  import fbs_pkg::*;
  ;
  localparam int WDL = 2000;
  logic        MCLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        WB_CYC_I = 1'b0;
  logic        WB_STB_I = 1'b0;
  logic        WB_WE_I = 1'b0;
  logic [3:0]  WB_ADR_I = 4'h0;
  logic [3:0]  WB_SEL_I = 4'hF;
  logic [31:0] WB_DAT_I = 32'h0;
  logic        NV_MASTER_MODE = 1'b0;
  logic        MASTER_TXD = 1'b0;
  logic        MASTER_RX_PULSE = 1'b0;
  logic [7:0]  SAFE_LVL_IN = 8'hFF;
  logic [3:0]  ext = 4'hF;
  logic [3:0]  pext = 4'hF;
  logic [31:0] WB_DAT_O, q, code;
  logic        WB_ACK_O, RX_STB, RX_OK, RX_MINE, TX_DATA, TX_ACTIVE;
  logic        DATA_STROBE_N, PARAM_STROBE_N, ROLE_MASTER, rok, cur_dx;
  logic        MASTER_RXD, MASTER_RX_STB;
  fbs_tlg_s    RX_TLG;
  logic [3:0]  DATA_PORT_OUT, DATA_PORT_OE, PARAM_PORT_OUT, PARAM_PORT_OE;
  logic [3:0]  rsp, oe_stb;
  int          mismatches = 0;
  int          checks_done = 0;
  int          stb_len;
  // Open-drain pins with pull-up: low wherever the block pulls
  wire  [3:0]  DATA_PORT_IN = ext & ~DATA_PORT_OE;
  wire  [3:0]  PARAM_PORT_IN = pext & ~PARAM_PORT_OE;
  wire         sn = cur_dx ? DATA_STROBE_N : PARAM_STROBE_N;
  always #25 MCLK = ~MCLK;
  fbs_slave_io #(.WDOG_LIMIT(WDL)) uut (
    .MCLK, .RSTN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
    .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .NV_MASTER_MODE, .RX_STB, .RX_OK,
    .RX_MINE, .RX_TLG, .DATA_PORT_IN, .DATA_PORT_OUT, .DATA_PORT_OE,
    .PARAM_PORT_IN, .PARAM_PORT_OUT, .PARAM_PORT_OE, .DATA_STROBE_N,
    .PARAM_STROBE_N, .SAFE_LVL_IN, .MASTER_TXD, .MASTER_RX_PULSE,
    .MASTER_RXD, .MASTER_RX_STB, .TX_DATA, .TX_ACTIVE, .ROLE_MASTER);
  fbs_master_model m (.MCLK, .TX_DATA, .TX_ACTIVE, .RX_STB, .RX_OK,
    .RX_MINE, .RX_TLG);
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      finish_test();
    end
  endtask
  // ==========================================================
  // Wishbone classic cycle; ack and read data taken at the same edge
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    @(posedge MCLK);
    while (WB_ACK_O !== 1'b1 && n < 20) begin
      @(posedge MCLK);
      n++;
    end
    bound(n, 20);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge MCLK);
  endtask
  // ==========================================================
  // One bus call; inputs change while the strobe is low
  task automatic call(input logic dx, input logic [4:0] a,
                      input logic [4:0] inf, input logic me,
                      input logic [3:0] late);
    int n;
    n = 0;
    cur_dx = dx;
    m.send(dx, a, inf, me, 1'b1);
    if (me) begin
      while (sn !== 1'b0 && n < 40) begin
        @(negedge MCLK);
        n++;
      end
      bound(n, 40);
      oe_stb = dx ? DATA_PORT_OE : PARAM_PORT_OE;
      n = 0;
      @(posedge MCLK);
      ext <= late;
      while (sn !== 1'b1 && n < 40) begin
        @(negedge MCLK);
        n++;
      end
      stb_len = n;
      m.get_resp(rsp, rok);
      chk(rok, 1'b1);
      bound(rok ? 0 : 1, 1);
    end else
      repeat (40) @(posedge MCLK);
    @(posedge MCLK);
  endtask
  task automatic gl(input logic [3:0] e);
    ext <= 4'hC;
    repeat (4) @(posedge MCLK);
    wb(0, OFS_STAT, 0);
    chk(q[3:0], e);
    ext <= 4'h3;
    repeat (40) @(posedge MCLK);
  endtask
  task automatic pulses(input logic ok, input int e);
    int c;
    c = 0;
    m.send(1'b1, 5'h05, 5'h00, 1'b1, ok);
    repeat (6) begin
      @(negedge MCLK);
      c += (MASTER_RX_STB === 1'b1);
    end
    chk(c, e);
    @(posedge MCLK);
  endtask
  initial begin
    repeat (100000) @(posedge MCLK);
    mismatches++;
    finish_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge MCLK);
    wb(0, OFS_CTRL, 0);
    chk(q, CTRL_RST);
    wb(0, OFS_CODE, 0);
    chk(q, CODE_RST);
    wb(0, 4'hC, 0);
    chk(q, 32'h0);
    wb(0, OFS_STAT, 0);
    chk({ROLE_MASTER, q[9:8]}, 3'h1);
    call(1, 5'h05, 5'h0A, 1, 4'hF);
    chk(oe_stb, 4'h5);
    chk(stb_len, STB_CYC);
    chk({DATA_PORT_OUT, PARAM_PORT_OUT}, 8'h00);
    call(1, 5'h05, 5'h02, 1, 4'hF);
    chk(DATA_PORT_OE, 4'hD);
    call(0, 5'h05, 5'h03, 1, 4'hF);
    chk({oe_stb, rsp}, 8'hC3);
    chk(stb_len, STB_CYC);
    wb(1, OFS_CTRL, 32'h3007);
    pext <= 4'h9;
    call(0, 5'h05, 5'h00, 1, 4'hF);
    chk(rsp, 4'h9);
    wb(1, OFS_CTRL, 32'h3000);
    call(1, 5'h05, 5'h00, 1, 4'h9);
    chk(rsp, 4'h9);
    wb(1, OFS_CTRL, 32'h3010);
    call(1, 5'h05, 5'h00, 1, 4'h3);
    chk(rsp, 4'hC);
    wb(1, OFS_CTRL, 32'hF020);
    repeat (40) @(posedge MCLK);
    gl(4'h3);
    wb(1, OFS_CTRL, 32'hF000);
    gl(4'hC);
    // Sync: first exchange, then a downward step releases outputs
    wb(1, OFS_CTRL, 32'h3040);
    call(1, 5'h0A, 5'h00, 0, ext);
    call(1, 5'h0C, 5'h06, 1, ext);
    wb(0, OFS_STAT, 0);
    chk(q[7:4], 4'h0);
    call(1, 5'h03, 5'h00, 0, ext);
    wb(0, OFS_STAT, 0);
    chk(q[7:4], 4'h6);
    call(1, 5'h0C, 5'h09, 1, ext);
    for (int i = 0; i < 4; i++) begin
      wb(0, OFS_STAT, 0);
      chk(q[7:4], i < 3 ? 4'h6 : 4'h9);
      if (i < 3)
        call(1, 5'h0C, 5'h00, 0, ext);
    end
    // Extended four-output mode with the alternation watchdog
    wb(1, OFS_CTRL, 32'h3380);
    call(1, 5'h05, 5'h05, 1, 4'hB);
    chk(rsp, 4'hB);
    call(1, 5'h05, 5'h02, 1, 4'hB);
    wb(0, OFS_STAT, 0);
    chk({q[11], q[7:4]}, 5'h06);
    repeat (WDL + 100) @(posedge MCLK);
    wb(0, OFS_STAT, 0);
    chk({q[11], q[7:4]}, 5'h1F);
    call(1, 5'h05, 5'h05, 1, 4'hB);
    wb(0, OFS_STAT, 0);
    chk(q[11], 1'b0);
    // Safety: table words with the enhanced input features set
    code = 32'h1F2E3D4C;
    wb(1, OFS_CODE, code);
    wb(1, OFS_CTRL, 32'h3470);
    for (int k = 0; k < 9; k++) begin
      call(1, 5'h05, 5'h00, 1, 4'h5);
      chk(rsp, code[4 * (k % 8) +: 4]);
    end
    SAFE_LVL_IN <= 8'hF7;
    call(1, 5'h05, 5'h00, 1, 4'h5);
    chk(rsp, FAULT_WORD);
    // Second reset into master role; strap moves later, role stays
    NV_MASTER_MODE <= 1'b1;
    RSTN <= 1'b0;
    repeat (8) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk(ROLE_MASTER, 1'b1);
    NV_MASTER_MODE <= 1'b0;
    MASTER_TXD <= 1'b1;
    MASTER_RX_PULSE <= 1'b1;
    repeat (6) @(posedge MCLK);
    chk({ROLE_MASTER, TX_DATA, MASTER_RXD}, 3'h7);
    MASTER_TXD <= 1'b0;
    MASTER_RX_PULSE <= 1'b0;
    repeat (6) @(posedge MCLK);
    chk({ROLE_MASTER, TX_DATA, MASTER_RXD}, 3'h4);
    pulses(1'b1, 1);
    pulses(1'b0, 0);
    finish_test();
  end
endmodule
